// ===== hdl/prcs_clock_select.sv
//Function
//- Pins four to seven drive same-numbered global lines
//- Pins 12..15 drive global lines 14,15,12,13
//- Enhanced loop reference: four pins or array clock
//- Enhanced select fixed until new configuration load
//- Center fast loop offers five reference inputs
//- Core logic may switch among center pin sources
//- Corner loop: corner pin, center pin, array clock
//- Each center pair may select any of four pins
//- Receiver mode: only adjacent pin pair compensated
//- Outside receiver mode all four pins compensated
//- Corner loop: only corner pin is compensated
`timescale 1ns/1ps
package prcs_pkg;
	localparam int             PRCS_PINS      = 16;
	localparam int             PRCS_LOOPS     = 4;
	localparam int             PRCS_GRP_PINS  = 4;
	// Enhanced loop source codes
	localparam logic [2:0]     PRCS_ENH_ARRAY = 3'h4;
	// Center loop source kind
	localparam logic           PRCS_CTR_PIN   = 1'h0;
	localparam logic           PRCS_CTR_ARRAY = 1'h1;
	// Corner loop source codes
	localparam logic [1:0]     PRCS_COR_CORNER = 2'h0;
	localparam logic [1:0]     PRCS_COR_CENTER = 2'h1;
	localparam logic [1:0]     PRCS_COR_ARRAY  = 2'h2;
	// First pin of each loop's group of four
	localparam int             PRCS_ENH_BASE [PRCS_LOOPS] = '{12, 4, 12, 4};
	localparam int             PRCS_CTR_BASE [PRCS_LOOPS] = '{0, 0, 8, 8};
	// Center pin reachable by each corner loop
	localparam int             PRCS_COR_CPIN [PRCS_LOOPS] = '{0, 2, 8, 10};
	// Pin driving each global line; -1 means no pin feed
	localparam int             PRCS_GMAP [PRCS_PINS] = '{
		-1, -1, -1, -1, 4, 5, 6, 7, -1, -1, -1, -1, 14, 15, 12, 13};
	typedef enum logic [0:0] {
		PRCS_CFG_EMPTY  = 1'b0,
		PRCS_CFG_LOADED = 1'b1
	} prcs_cfg_t;
endpackage

module prcs_clock_select
	import prcs_pkg::*;
(
	input  wire logic                  mclk_i,
	input  wire logic                  reset_n_i,
	input  wire logic [PRCS_PINS-1:0]  clk_pin_i,
	input  wire logic [PRCS_LOOPS-1:0] corner_loop_reference_pin_i,
	input  wire logic                  array_clk_i,
	input  wire logic                  cfg_load_i,
	input  wire logic [PRCS_LOOPS-1:0][2:0] cfg_enh_sel_i,
	input  wire logic [PRCS_LOOPS-1:0] cfg_ctr_src_i,
	input  wire logic [PRCS_LOOPS-1:0] cfg_ctr_rx_mode_i,
	input  wire logic [PRCS_LOOPS-1:0][1:0] cfg_cor_sel_i,
	input  wire logic [PRCS_LOOPS-1:0][1:0] core_ctr_pin_sel_i,
	output logic                       cfg_loaded_o,
	output logic      [PRCS_PINS-1:0]  global_clock_line_o,
	output logic      [PRCS_LOOPS-1:0] enh_ref_o,
	output logic      [PRCS_LOOPS-1:0] ctr_ref_o,
	output logic      [PRCS_LOOPS-1:0] ctr_comp_o,
	output logic      [PRCS_LOOPS-1:0] cor_ref_o,
	output logic      [PRCS_LOOPS-1:0] cor_comp_o
);
	// ****************************************************
	// Input synchronisers
	// ****************************************************
	logic [PRCS_PINS-1:0]  pin_s;
	logic [PRCS_LOOPS-1:0] cor_pin_s;
	logic                  array_s;

	prcs_sync #(.W(PRCS_PINS)) u_sync_pin (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.d_i       (clk_pin_i),
		.q_o       (pin_s)
	);

	prcs_sync #(.W(PRCS_LOOPS)) u_sync_cor (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.d_i       (corner_loop_reference_pin_i),
		.q_o       (cor_pin_s)
	);

	// Array clock is assumed qualified by its source
	prcs_sync #(.W(1)) u_sync_arr (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.d_i       (array_clk_i),
		.q_o       (array_s)
	);

	// ****************************************************
	// Configuration image
	// ****************************************************
	prcs_cfg_t                   cfg_state_reg;
	logic [PRCS_LOOPS-1:0][2:0]  enh_sel_reg;
	logic [PRCS_LOOPS-1:0]       ctr_src_reg;
	logic [PRCS_LOOPS-1:0]       ctr_rx_reg;
	logic [PRCS_LOOPS-1:0][1:0]  cor_sel_reg;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_state_reg <= PRCS_CFG_EMPTY;
		end else begin
			case (cfg_state_reg)
				PRCS_CFG_EMPTY: begin
					if (cfg_load_i) begin
						cfg_state_reg <= PRCS_CFG_LOADED;
					end
				end
				PRCS_CFG_LOADED: begin
					cfg_state_reg <= PRCS_CFG_LOADED;
				end
				default: begin
					cfg_state_reg <= PRCS_CFG_EMPTY;
				end
			endcase
		end
	end

	// Selects change only on a configuration load
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			enh_sel_reg <= '0;
			ctr_src_reg <= '0;
			ctr_rx_reg  <= '0;
			cor_sel_reg <= '0;
		end else if (cfg_load_i) begin
			enh_sel_reg <= cfg_enh_sel_i;
			ctr_src_reg <= cfg_ctr_src_i;
			ctr_rx_reg  <= cfg_ctr_rx_mode_i;
			cor_sel_reg <= cfg_cor_sel_i;
		end
	end

	assign cfg_loaded_o = (cfg_state_reg == PRCS_CFG_LOADED);

	// ****************************************************
	// Global clock lines fed by dedicated pins
	// ****************************************************
	logic [PRCS_PINS-1:0] gcl_next;

	genvar g;
	generate
		for (g = 0; g < PRCS_PINS; g++) begin : g_global_clock_line
			if (PRCS_GMAP[g] >= 0) begin : g_fed
				assign gcl_next[g] = pin_s[PRCS_GMAP[g]];
			end else begin : g_none
				assign gcl_next[g] = 1'b0;
			end
		end
	endgenerate

	// One register for all lines; unfed lines stay low
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			global_clock_line_o <= '0;
		end else begin
			global_clock_line_o <= gcl_next;
		end
	end

	// ****************************************************
	// Per-loop reference multiplexers
	// ****************************************************
	genvar l;
	generate
		for (l = 0; l < PRCS_LOOPS; l++) begin : g_loop
			logic [PRCS_GRP_PINS-1:0] enh_grp;
			logic [PRCS_GRP_PINS-1:0] ctr_grp;
			logic                     enh_next;
			logic                     ctr_next;
			logic                     ctr_comp_next;
			logic                     cor_next;
			logic                     near_pair;

			assign enh_grp = pin_s[PRCS_ENH_BASE[l] +: PRCS_GRP_PINS];
			assign ctr_grp = pin_s[PRCS_CTR_BASE[l] +: PRCS_GRP_PINS];
			// Even loop of a pair sits beside pins 0,1; odd beside 2,3
			assign near_pair = (core_ctr_pin_sel_i[l][1] == l[0]);

			always_comb begin
				if (enh_sel_reg[l] == PRCS_ENH_ARRAY) begin
					enh_next = array_s;
				end else if (enh_sel_reg[l] < PRCS_ENH_ARRAY) begin
					enh_next = enh_grp[enh_sel_reg[l][1:0]];
				end else begin
					enh_next = 1'b0;
				end
			end

			always_comb begin
				if (ctr_src_reg[l] == PRCS_CTR_ARRAY) begin
					ctr_next      = array_s;
					ctr_comp_next = 1'b0;
				end else begin
					// Core drives the pin choice live
					ctr_next      = ctr_grp[core_ctr_pin_sel_i[l]];
					ctr_comp_next = ctr_rx_reg[l] ? near_pair : 1'b1;
				end
			end

			always_comb begin
				case (cor_sel_reg[l])
					PRCS_COR_CORNER: cor_next = cor_pin_s[l];
					PRCS_COR_CENTER: cor_next = pin_s[PRCS_COR_CPIN[l]];
					PRCS_COR_ARRAY:  cor_next = array_s;
					default:         cor_next = 1'b0;
				endcase
			end

			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					enh_ref_o[l]  <= 1'b0;
					ctr_ref_o[l]  <= 1'b0;
					ctr_comp_o[l] <= 1'b0;
					cor_ref_o[l]  <= 1'b0;
					cor_comp_o[l] <= 1'b0;
				end else begin
					enh_ref_o[l]  <= enh_next;
					ctr_ref_o[l]  <= ctr_next;
					ctr_comp_o[l] <= ctr_comp_next;
					cor_ref_o[l]  <= cor_next;
					cor_comp_o[l] <= (cor_sel_reg[l] == PRCS_COR_CORNER);
				end
			end
		end
	endgenerate
endmodule

// ===== hdl/prcs_sync.sv
`timescale 1ns/1ps
module prcs_sync
	import prcs_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= '0;
			q_o      <= '0;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule

// ===== tb/prcs_clock_select_assertions.sv
`timescale 1ns/1ps
module prcs_chk
	import prcs_pkg::*;
(
	input wire logic		mclk_i,
	input wire logic		reset_n_i,
	input wire logic [15:0]	clk_pin_i,
	input wire logic		cfg_load_i,
	input wire logic [3:0]	cfg_ctr_src_i,
	input wire logic [3:0]	cfg_ctr_rx_mode_i,
	input wire logic [3:0][1:0]	cfg_cor_sel_i,
	input wire logic [3:0][1:0]	core_ctr_pin_sel_i,
	input wire logic		cfg_loaded_o,
	input wire logic [15:0]	global_clock_line_o,
	input wire logic [3:0]	ctr_comp_o,
	input wire logic [3:0]	cor_comp_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	gl_same_a: assert property (reset_n_i[*3] |=>
		global_clock_line_o[7:4] == $past(clk_pin_i[7:4], 3))
		else $error("same-number line mismatch");
	gl_swap_a: assert property (reset_n_i[*3] |=>
		global_clock_line_o[15:12] == {$past(clk_pin_i[13:12], 3),
		$past(clk_pin_i[15:14], 3)}) else $error("swapped line mismatch");
	gl_unfed_a: assert property (
		{global_clock_line_o[11:8], global_clock_line_o[3:0]} == 8'h00)
		else $error("unfed line active");
	load_flag_a: assert property (cfg_load_i |=> cfg_loaded_o)
		else $error("load not flagged");
	loaded_hold_a: assert property (cfg_loaded_o |=> cfg_loaded_o)
		else $error("load flag dropped");
	cor_comp_a: assert property (cfg_load_i ##1 !cfg_load_i[*3] |->
		cor_comp_o[0] == ($past(cfg_cor_sel_i[0], 3) == PRCS_COR_CORNER))
		else $error("corner compensation wrong");
	ctr_rx_a: assert property (cfg_load_i && cfg_ctr_rx_mode_i[0] &&
		!cfg_ctr_src_i[0] ##1 !cfg_load_i[*3] ##0
		$stable(core_ctr_pin_sel_i[0]) |->
		ctr_comp_o[0] == (core_ctr_pin_sel_i[0] < 2'h2))
		else $error("receiver compensation wrong");
	ctr_norx_a: assert property (cfg_load_i && !cfg_ctr_rx_mode_i[1] &&
		!cfg_ctr_src_i[1] ##1 !cfg_load_i[*3] |-> ctr_comp_o[1])
		else $error("pin source not compensated");
endmodule
bind prcs_clock_select prcs_chk u_chk (.mclk_i, .reset_n_i, .clk_pin_i,
	.cfg_load_i, .cfg_ctr_src_i, .cfg_ctr_rx_mode_i, .cfg_cor_sel_i,
	.core_ctr_pin_sel_i, .cfg_loaded_o, .global_clock_line_o,
	.ctr_comp_o, .cor_comp_o);

// ===== tb/prcs_src_model.sv
`timescale 1ns/1ps
module prcs_src_model (
	input  wire logic		mclk_i,
	input  wire logic [15:0]	pat_i,
	input  wire logic [3:0]	cpat_i,
	input  wire logic		arr_i,
	output logic [15:0]		clk_pin_o,
	output logic [3:0]		cor_pin_o,
	output logic			arr_clk_o
);
	always_ff @(posedge mclk_i) begin
		clk_pin_o <= pat_i;
		cor_pin_o <= cpat_i;
		arr_clk_o <= arr_i;
	end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic			mclk_i = 1'b0;
	logic			reset_n_i = 1'b0;
	logic			cfg_load_i = 1'b0;
	logic			arr_v = 1'b0;
	logic [15:0]		pat = 16'h0000;
	logic [3:0]		cpat = 4'h0;
	logic [3:0]		ctr_src = 4'h0;
	logic [3:0]		rx = 4'h0;
	logic [3:0][2:0]	enh = 12'h000;
	logic [3:0][1:0]	cor = 8'h00;
	logic [3:0][1:0]	core = 8'h00;
	logic [15:0]		pins, gl;
	logic [3:0]		cpins, enh_r, ctr_r, ctr_c, cor_r, cor_c;
	logic			arr_clk, loaded;
	int			num_errors = 0;
	int			comparisons = 0;
	prcs_src_model u_src (.mclk_i, .pat_i(pat), .cpat_i(cpat),
		.arr_i(arr_v), .clk_pin_o(pins), .cor_pin_o(cpins),
		.arr_clk_o(arr_clk));
	prcs_clock_select u_dut (.mclk_i, .reset_n_i, .clk_pin_i(pins),
		.corner_loop_reference_pin_i(cpins), .array_clk_i(arr_clk),
		.cfg_load_i, .cfg_enh_sel_i(enh), .cfg_ctr_src_i(ctr_src),
		.cfg_ctr_rx_mode_i(rx), .cfg_cor_sel_i(cor),
		.core_ctr_pin_sel_i(core), .cfg_loaded_o(loaded),
		.global_clock_line_o(gl), .enh_ref_o(enh_r), .ctr_ref_o(ctr_r),
		.ctr_comp_o(ctr_c), .cor_ref_o(cor_r), .cor_comp_o(cor_c));
	initial forever #5 mclk_i = ~mclk_i;
	task automatic chk(input string n, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic step();
		repeat (5) @(negedge mclk_i);
	endtask
	task automatic load();
		cfg_load_i = 1'b1;
		@(negedge mclk_i) cfg_load_i = 1'b0;
		step();
	endtask
	task automatic t_glob();
		pat = 16'h6c3a;
		step();
		chk("gl", gl, {pat[13:12], pat[15:14], 4'h0, pat[7:4], 4'h0});
		chk("loaded0", 16'(loaded), 16'h0000);
	endtask
	task automatic t_enh();
		logic [15:0] e;
		pat = 16'h50a0;
		arr_v = 1'b1;
		for (int k = 0; k < 6; k++) begin
			enh[0] = 3'(k);
			enh[1] = 3'(k);
			load();
			e = (k < 4) ? {14'h0, pat[4 + k], pat[12 + k]} :
				(k == 4) ? 16'h0003 : 16'h0000;
			chk("enh", 16'(enh_r[1:0]), e);
			chk("loaded", 16'(loaded), 16'h0001);
		end
		arr_v = 1'b0;
		enh[0] = 3'h0;
		step();
		chk("enh_hold", 16'(enh_r[0]), 16'h0000);
	endtask
	task automatic t_ctr();
		pat = 16'h0a05;
		rx = 4'hd;
		load();
		for (int k = 0; k < 4; k++) begin
			core[0] = 2'(k);
			core[1] = 2'(k);
			core[3] = 2'(k);
			step();
			chk("ctr_ref", 16'(ctr_r[1:0]), 16'({2{pat[k]}}));
			chk("ctr_ref3", 16'(ctr_r[3]), 16'(pat[8 + k]));
			chk("ctr_comp", 16'(ctr_c[1:0]), 16'({1'b1, k < 2}));
			chk("ctr_comp3", 16'(ctr_c[3]), 16'(k >= 2));
		end
		// Settle receiver loops back on their matched pins
		core[0] = 2'h0;
		core[1] = 2'h0;
		core[3] = 2'h2;
		step();
		chk("ctr_rx_ok", 16'({ctr_c[3], ctr_c[0]}), 16'h0003);
		ctr_src = 4'h3;
		arr_v = 1'b1;
		load();
		chk("ctr_arr", 16'(ctr_r[1:0]), 16'h0003);
		chk("arr_comp", 16'(ctr_c[1:0]), 16'h0000);
	endtask
	task automatic t_cor();
		for (int k = 0; k < 4; k++) begin
			cor[0] = 2'(k);
			cpat = {3'h0, k == 0 || k == 3};
			pat = {15'h0, k == 1 || k == 3};
			arr_v = (k >= 2);
			load();
			chk("cor_ref", 16'(cor_r[0]), 16'(k < 3));
			chk("cor_comp", 16'(cor_c[0]), 16'(k == 0));
		end
	endtask
	task automatic test_done();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge mclk_i);
		reset_n_i = 1'b1;
		t_glob();
		t_enh();
		t_ctr();
		t_cor();
		test_done();
	end
	initial begin
		#20us;
		num_errors++;
		test_done();
	end
endmodule
